// ### logic/fhs_pkg.sv
// Package for the fault hiccup sequencer: states, carriers and counts.
// Assumes every count is in switching-period ticks, not system clocks.
package fhs_pkg;

  // Width of the shared tick counter
  localparam int unsigned CNT_W = 13;

  // Soft-start delay length in switching cycles
  localparam logic [CNT_W-1:0] SS_DELAY_TICKS = 13'h0040;
  // Soft-start ramp length in switching cycles; plain default
  localparam logic [CNT_W-1:0] SS_RAMP_TICKS = 13'h0500;
  // Overcurrent hiccup wait in switching cycles
  localparam logic [CNT_W-1:0] OC_WAIT_TICKS = 13'h1000;
  // Counter reset value
  localparam logic [CNT_W-1:0] CNT_RST = 13'h0000;

  // Number of phases driven
  localparam int unsigned PHASES = 2;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_PREPOR,
    ST_SHUTDOWN,
    ST_SS_DELAY,
    ST_SS_RAMP,
    ST_RUN,
    ST_OC_WAIT,
    ST_OPEN_SENSE
  } fhs_state_t;

  // Comparator results from the analog fault monitors
  typedef struct packed {
    logic open_sense;   // Local sense above remote difference plus one volt
    logic overcurrent;  // Droop sense above overcurrent threshold
    logic undervolt;    // Output below undervoltage window
    logic overvolt;     // Output above overvoltage trip level
  } fhs_sense_t;

  // Gate drive permissions per phase
  typedef struct packed {
    logic [PHASES-1:0] high_side;
    logic [PHASES-1:0] low_side;
  } fhs_gate_t;

  // Gate drive reset value: everything off
  localparam fhs_gate_t GATE_OFF = '{high_side: 2'h0, low_side: 2'h0};

endpackage

// ### logic/fhs_sequencer.sv
// Fault hiccup sequencer: open-sense shutdown, overcurrent hiccup, pre-POR clamp.
// Assumes comparator inputs and the switching tick are synchronous to sys_clk.
//
// Summary of operation
// - Open sense line shuts the controller down
// - Open sense cleared restarts soft-start from start
// - Droop above threshold flags overcurrent, enters protection
// - Overcurrent shutdown turns all gate drives off
// - Gates stay off 4096 wait cycles plus the 64-cycle soft-start delay
// - Wait over and enabled starts new soft-start
// - Trip, wait, retry repeats without limit
// - Bias supply loss re-enters pre-POR low-side clamp
// - Power-ok pulled low on faults or disable
// - Soft-start is 64-cycle delay then ramp
`timescale 1ns/1ps

module fhs_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Switching period tick, one cycle per switching period
  input wire logic sw_tick,
  // Enable and power-on conditions
  input wire logic threshold_enable_input,
  input wire logic vcc_por_ok,
  input wire logic driver_bias_supply_ok,
  // Fault comparators
  input wire fhs_pkg::fhs_sense_t sense,
  // Gate drive permissions
  output fhs_pkg::fhs_gate_t gate_ff,
  // Power-ok open-drain pin: level and enable, enable low drives low
  output logic power_ok_output_o_ff,
  output logic power_ok_output_oe_n_ff,
  // Status
  output logic oc_fault_ff,
  output logic open_sense_fault_ff,
  output logic ss_ramp_ff,
  output logic prepor_clamp_ff
);

  // Sequencer state and its next value
  fhs_pkg::fhs_state_t state_ff;
  fhs_pkg::fhs_state_t nxt_state;
  // Shared tick counter for delay, ramp and hiccup wait
  logic [fhs_pkg::CNT_W-1:0] cnt_ff;
  logic [fhs_pkg::CNT_W-1:0] nxt_cnt;
  // Both bias supplies above their power-on thresholds
  logic por_ok;
  // Controller allowed to run
  logic run_ok;
  // Tick that completes the current timed phase
  logic delay_done;
  logic ramp_done;
  logic wait_done;
  fhs_pkg::fhs_gate_t nxt_gate;
  logic nxt_power_ok_output;

  assign por_ok = vcc_por_ok & driver_bias_supply_ok;
  assign run_ok = por_ok & threshold_enable_input;
  assign delay_done = sw_tick & (cnt_ff == fhs_pkg::SS_DELAY_TICKS - 13'h0001);
  assign ramp_done = sw_tick & (cnt_ff == fhs_pkg::SS_RAMP_TICKS - 13'h0001);
  assign wait_done = sw_tick & (cnt_ff == fhs_pkg::OC_WAIT_TICKS - 13'h0001);

  // Next state: supply loss, then disable, then open sense, then per state
  always_comb begin
    nxt_state = state_ff;
    if (!por_ok) begin
      nxt_state = fhs_pkg::ST_PREPOR;
    end else if (!threshold_enable_input) begin
      nxt_state = fhs_pkg::ST_SHUTDOWN;
    end else if (sense.open_sense) begin
      nxt_state = fhs_pkg::ST_OPEN_SENSE;
    end else begin
      case (state_ff)
        // Conditions met or open sense cleared: fresh soft-start
        fhs_pkg::ST_PREPOR,
        fhs_pkg::ST_SHUTDOWN,
        fhs_pkg::ST_OPEN_SENSE: begin
          nxt_state = fhs_pkg::ST_SS_DELAY;
        end
        // Initial delay before the reference ramp
        fhs_pkg::ST_SS_DELAY: begin
          if (sense.overcurrent) begin
            nxt_state = fhs_pkg::ST_OC_WAIT;
          end else if (delay_done) begin
            nxt_state = fhs_pkg::ST_SS_RAMP;
          end
        end
        // Reference ramp paced by the switching tick
        fhs_pkg::ST_SS_RAMP: begin
          if (sense.overcurrent) begin
            nxt_state = fhs_pkg::ST_OC_WAIT;
          end else if (ramp_done) begin
            nxt_state = fhs_pkg::ST_RUN;
          end
        end
        // Regulating
        fhs_pkg::ST_RUN: begin
          if (sense.overcurrent) begin
            nxt_state = fhs_pkg::ST_OC_WAIT;
          end
        end
        // Hiccup wait, then retry while still enabled
        fhs_pkg::ST_OC_WAIT: begin
          if (wait_done) begin
            nxt_state = fhs_pkg::ST_SS_DELAY;
          end
        end
        default: begin
          nxt_state = fhs_pkg::ST_SHUTDOWN;
        end
      endcase
    end
  end

  // Counter restarts on every state change and advances once per tick
  always_comb begin
    if (nxt_state != state_ff) begin
      nxt_cnt = fhs_pkg::CNT_RST;
    end else if (sw_tick) begin
      nxt_cnt = cnt_ff + 13'h0001;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  // Gate permissions follow the next state so changes take effect at once
  always_comb begin
    nxt_gate = fhs_pkg::GATE_OFF;
    case (nxt_state)
      // Low-side path clamps the output before power-on
      fhs_pkg::ST_PREPOR: begin
        nxt_gate.low_side = 2'h3;
      end
      // Switching permitted during ramp and regulation; overvolt keeps only the low sides on
      fhs_pkg::ST_SS_RAMP,
      fhs_pkg::ST_RUN: begin
        if (sense.overvolt) begin
          nxt_gate.low_side = 2'h3;
        end else begin
          nxt_gate.high_side = 2'h3;
          nxt_gate.low_side = 2'h3;
        end
      end
      // Hiccup wait, shutdown, open sense and delay keep all gates off
      default: begin
        nxt_gate = fhs_pkg::GATE_OFF;
      end
    endcase
  end

  // Power-ok only in regulation with no active fault
  assign nxt_power_ok_output = (nxt_state == fhs_pkg::ST_RUN) & ~sense.undervolt & ~sense.overvolt
    & ~sense.overcurrent;

  // State register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= fhs_pkg::ST_PREPOR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Tick counter register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= fhs_pkg::CNT_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Gate permission register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gate_ff <= fhs_pkg::GATE_OFF;
    end else begin
      gate_ff <= nxt_gate;
    end
  end

  // Power-ok pin: level always low, enable releases the pin when good
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      power_ok_output_o_ff <= 1'b0;
      power_ok_output_oe_n_ff <= 1'b0;
    end else begin
      power_ok_output_o_ff <= 1'b0;
      power_ok_output_oe_n_ff <= nxt_power_ok_output;
    end
  end

  // Status flags follow the next state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      oc_fault_ff <= 1'b0;
      open_sense_fault_ff <= 1'b0;
      ss_ramp_ff <= 1'b0;
      prepor_clamp_ff <= 1'b0;
    end else begin
      oc_fault_ff <= (nxt_state == fhs_pkg::ST_OC_WAIT);
      open_sense_fault_ff <= (nxt_state == fhs_pkg::ST_OPEN_SENSE);
      ss_ramp_ff <= (nxt_state == fhs_pkg::ST_SS_RAMP);
      prepor_clamp_ff <= (nxt_state == fhs_pkg::ST_PREPOR);
    end
  end

  // Checks on the sequencer
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Enabled with supplies good and no open sense
  sequence s_clean;
    run_ok && !sense.open_sense;
  endsequence

  // Overcurrent seen in an active state
  sequence s_oc_trip;
    s_clean ##0 sense.overcurrent && (state_ff == fhs_pkg::ST_RUN
      || state_ff == fhs_pkg::ST_SS_RAMP || state_ff == fhs_pkg::ST_SS_DELAY);
  endsequence

  a_open_shut_down: assert property (
    run_ok && sense.open_sense |=> state_ff == fhs_pkg::ST_OPEN_SENSE
      && gate_ff == fhs_pkg::GATE_OFF && open_sense_fault_ff)
    else $error("open sense did not shut down");

  a_open_restart_ss: assert property (
    state_ff == fhs_pkg::ST_OPEN_SENSE ##0 s_clean |=> state_ff == fhs_pkg::ST_SS_DELAY
      && cnt_ff == fhs_pkg::CNT_RST)
    else $error("open sense clear did not restart soft-start");

  a_oc_trip_flag: assert property (
    s_oc_trip |=> oc_fault_ff && state_ff == fhs_pkg::ST_OC_WAIT)
    else $error("overcurrent not flagged");

  a_oc_gates_off: assert property (
    s_oc_trip |=> gate_ff == fhs_pkg::GATE_OFF
      ##1 (!$past(por_ok) || gate_ff == fhs_pkg::GATE_OFF))
    else $error("gates not off in overcurrent shutdown");

  a_oc_wait_hold: assert property (
    state_ff == fhs_pkg::ST_OC_WAIT && !wait_done ##0 s_clean
      |=> state_ff == fhs_pkg::ST_OC_WAIT && gate_ff == fhs_pkg::GATE_OFF)
    else $error("hiccup wait ended early");

  a_oc_wait_retry: assert property (
    state_ff == fhs_pkg::ST_OC_WAIT && sw_tick
      && cnt_ff == fhs_pkg::OC_WAIT_TICKS - 13'h0001 ##0 s_clean
      |=> state_ff == fhs_pkg::ST_SS_DELAY)
    else $error("no retry after hiccup wait");

  a_retry_repeats: assert property (
    state_ff == fhs_pkg::ST_SS_DELAY ##0 s_oc_trip |=> state_ff == fhs_pkg::ST_OC_WAIT
      && cnt_ff == fhs_pkg::CNT_RST)
    else $error("retry did not trip again");

  a_prepor_clamp: assert property (
    !por_ok |=> state_ff == fhs_pkg::ST_PREPOR && gate_ff.low_side == 2'h3
      && gate_ff.high_side == 2'h0 && !power_ok_output_oe_n_ff)
    else $error("pre-POR clamp missing");

  a_power_ok_output_low: assert property (
    !threshold_enable_input || !por_ok || sense.overcurrent || sense.undervolt
      || sense.overvolt |=> !power_ok_output_oe_n_ff)
    else $error("power ok not pulled low");

  a_ss_delay_len: assert property (
    state_ff == fhs_pkg::ST_SS_DELAY && delay_done ##0 s_clean ##0 !sense.overcurrent
      |=> state_ff == fhs_pkg::ST_SS_RAMP && ss_ramp_ff
      && $past(cnt_ff) == fhs_pkg::SS_DELAY_TICKS - 13'h0001)
    else $error("soft-start delay length wrong");

  a_wait_disable: assert property (
    state_ff == fhs_pkg::ST_OC_WAIT && por_ok && !threshold_enable_input
      |=> state_ff == fhs_pkg::ST_SHUTDOWN && cnt_ff == fhs_pkg::CNT_RST)
    else $error("disable during wait not handled");

  a_open_priority: assert property (
    run_ok && sense.open_sense |=> state_ff != fhs_pkg::ST_SS_DELAY && !oc_fault_ff)
    else $error("soft-start began with open sense");

endmodule

// ### bench/fhs_stage_model.sv
// Model of the power stage and analog monitors facing the sequencer.
// Assumes the bench sets the fault commands at the rising edge of sys_clk.
`timescale 1ns/1ps

module fhs_stage_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Fault commands from the bench
  input wire logic short_cmd,
  input wire logic open_cmd,
  input wire logic uv_cmd,
  input wire logic ov_cmd,
  // Tick and comparator results to the sequencer
  output logic sw_tick_ff,
  output fhs_pkg::fhs_sense_t sense
);
  // Switching tick on every clock, so the long counts pass quickly
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sw_tick_ff <= 1'b0;
    end else begin
      sw_tick_ff <= 1'b1;
    end
  end

  // A shorted load trips current whatever the gates do; overvolt on command
  assign sense = '{open_sense: open_cmd, overcurrent: short_cmd, undervolt: uv_cmd,
                   overvolt: ov_cmd};
endmodule

// ### bench/tb_fhs_sequencer.sv
// Self-checking bench for the fault hiccup sequencer.
// Assumes the stage model ticks every clock, so counts equal cycles.
`timescale 1ns/1ps

module tb_fhs_sequencer;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic en = 1'b1;
  logic por_ok = 1'b1;
  logic bias_ok = 1'b1;
  logic short_cmd = 1'b0;
  logic open_cmd = 1'b0;
  logic uv_cmd = 1'b0;
  logic ov_cmd = 1'b0;
  logic sw_tick;
  fhs_pkg::fhs_sense_t sense;
  fhs_pkg::fhs_gate_t gate;
  logic pg_o, pg_oe_n, oc_flag, os_flag, ramp_flag, clamp_flag;
  int miscompares = 0;
  int n_tests = 0;
  int n;

  // 50 ns clock
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  fhs_stage_model stage (.sys_clk(sys_clk), .rstn(rstn), .short_cmd(short_cmd),
    .open_cmd(open_cmd), .uv_cmd(uv_cmd), .ov_cmd(ov_cmd), .sw_tick_ff(sw_tick),
    .sense(sense));

  fhs_sequencer dut (.sys_clk(sys_clk), .rstn(rstn), .sw_tick(sw_tick),
    .threshold_enable_input(en), .vcc_por_ok(por_ok), .driver_bias_supply_ok(bias_ok),
    .sense(sense), .gate_ff(gate), .power_ok_output_o_ff(pg_o),
    .power_ok_output_oe_n_ff(pg_oe_n), .oc_fault_ff(oc_flag),
    .open_sense_fault_ff(os_flag), .ss_ramp_ff(ramp_flag), .prepor_clamp_ff(clamp_flag));

  // Status flag picked by index
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = ramp_flag;
      1: pick = oc_flag;
      2: pick = os_flag;
      default: pick = clamp_flag;
    endcase
  endfunction

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Let the edge's updates land before sampling
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  // Bounded wait for a flag to reach a level
  task automatic wait_lvl(input int sel, input logic v, input int bound);
    for (int i = 0; i < bound && pick(sel) !== v; i++) step();
    chk($sformatf("flag %0d", sel), {15'h0, v}, {15'h0, pick(sel)});
    if (pick(sel) !== v) report_and_stop();
  endtask

  // Cycles for which a flag stays high
  task automatic span(input int sel, output int cnt);
    cnt = 0;
    while (pick(sel) === 1'b1 && cnt < 9000) begin
      cnt++;
      step();
    end
    if (cnt >= 9000) begin
      miscompares++;
      $display("MISMATCH span of flag %0d expected end seen none", sel);
      report_and_stop();
    end
  endtask

  task automatic t_run();
    span(0, n);
    chk("ramp len", 16'h0500, n[15:0]);
    chk("run gates", 16'h000F, {12'h0, gate});
    chk("run pg", 16'h0001, {15'h0, pg_oe_n});
    $display("test run done");
  endtask

  task automatic t_hiccup();
    @(posedge sys_clk) short_cmd <= 1'b1;
    wait_lvl(1, 1'b1, 4);
    chk("oc gates", 16'h0000, {12'h0, gate});
    chk("oc pg", 16'h0000, {15'h0, pg_oe_n});
    span(1, n);
    chk("oc wait", 16'h1000, n[15:0]);
    wait_lvl(1, 1'b1, 4);
    $display("test hiccup done");
  endtask

  task automatic t_disable();
    repeat (10) step();
    @(posedge sys_clk) en <= 1'b0;
    wait_lvl(1, 1'b0, 4);
    chk("off gates", 16'h0000, {12'h0, gate});
    chk("off pg", 16'h0000, {15'h0, pg_oe_n});
    @(posedge sys_clk) en <= 1'b1;
    wait_lvl(1, 1'b1, 4);
    $display("test disable done");
  endtask

  task automatic t_open();
    int bad;
    bad = 0;
    @(posedge sys_clk) open_cmd <= 1'b1;
    wait_lvl(2, 1'b1, 4);
    chk("open gates", 16'h0000, {12'h0, gate});
    for (int i = 0; i < 5000; i++) begin
      step();
      if (ramp_flag !== 1'b0 || oc_flag !== 1'b0 || os_flag !== 1'b1) bad++;
    end
    chk("open hold", 16'h0000, bad[15:0]);
    @(posedge sys_clk) begin
      open_cmd <= 1'b0;
      short_cmd <= 1'b0;
    end
    wait_lvl(2, 1'b0, 4);
    n = 0;
    while (ramp_flag !== 1'b1 && n < 200) begin
      n++;
      step();
    end
    chk("ss delay", 16'h0040, n[15:0]);
    if (n >= 200) report_and_stop();
    $display("test open done");
  endtask

  task automatic t_uv_bias();
    @(posedge sys_clk) ov_cmd <= 1'b1;
    step();
    step();
    chk("ov pg", 16'h0000, {15'h0, pg_oe_n});
    @(posedge sys_clk) begin
      ov_cmd <= 1'b0;
      uv_cmd <= 1'b1;
    end
    step();
    step();
    chk("uv pg", 16'h0000, {15'h0, pg_oe_n});
    @(posedge sys_clk) bias_ok <= 1'b0;
    wait_lvl(3, 1'b1, 4);
    chk("clamp gates", 16'h0003, {12'h0, gate});
    chk("clamp pg", 16'h0000, {14'h0, pg_oe_n, pg_o});
    @(posedge sys_clk) bias_ok <= 1'b1;
    wait_lvl(3, 1'b0, 4);
    $display("test uv bias done");
  endtask

  // Main sequence: reset, start-up, faults, verdict
  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    wait_lvl(0, 1'b1, 200);
    t_run();
    t_hiccup();
    t_disable();
    t_open();
    t_run();
    t_uv_bias();
    report_and_stop();
  end
endmodule
